/* hw/mss_slave.v */
// Management serial slave that reads and writes per-port configuration words.
// Function
// R1: Address is 1011 plus three strap bits.
// R2: Slave only; clock and data are two-way.
// R3: Read/write registers reachable over serial.
// R4: Preset-only registers also writable and readable.
// R5: Master writes target, then data, command 08h.
// R6: First transaction: offset byte, then port byte.
// R7: Port selector 0..3 valid, others reserved.
// R8: Second transaction: low byte, then high byte.
// R9: Ninth bit acknowledges each byte.
// R10: Address byte bit 0 selects read/write.
// R11: Read returns low byte then high byte.
// R12: Commit only after both data bytes acknowledged.
// R13: Reserved port or bad command changes nothing.
`timescale 1ns/1ns
`include "mss_map.vh"
module mss_slave (
    // Clock and reset
    input  wire        CLK_I,
    input  wire        RESETN_I,
    // Address straps
    input  wire [2:0]  ADDR_STRAP_I,
    // Serial clock pin
    input  wire        SCL_I,
    output wire        SCL_O,
    output wire        SCL_OE_O,
    // Serial data pin
    input  wire        SDA_I,
    output wire        SDA_O,
    output wire        SDA_OE_O,
    // Register view
    input  wire [1:0]  RD_PORT_I,
    input  wire [7:0]  RD_OFFSET_I,
    output wire [15:0] RD_DATA_O,
    output reg         WR_STROBE_O,
    output reg  [1:0]  WR_PORT_O,
    output reg  [7:0]  WR_OFFSET_O,
    output reg  [15:0] WR_DATA_O
);
    localparam ST_IDLE = 3'h0;
    localparam ST_ADDR = 3'h1;
    localparam ST_RX   = 3'h2;
    localparam ST_TX   = 3'h3;
    localparam ST_SKIP = 3'h4;

    wire       scl;
    wire       sda;
    reg        scl_d_reg;
    reg        sda_d_reg;
    reg  [2:0] state_reg;
    reg  [3:0] bit_reg;
    reg  [7:0] shift_reg;
    reg  [2:0] byte_reg;
    reg        ack_reg;
    reg        sda_low_reg;
    reg        cmd_ok_reg;
    reg        tgt_reg;
    reg        tx_hi_reg;
    reg        mack_reg;
    reg  [6:0] my_addr_reg;
    reg  [7:0] off_reg;
    reg  [7:0] port_reg;
    reg  [7:0] dlo_reg;
    reg  [15:0] mem [0:1023];
    wire [9:0] rd_idx;
    wire [9:0] tx_idx;
    wire [2:0] strap;
    genvar     g;

    mss_pin_sync u_scl (
        .CLK_I    (CLK_I),
        .RESETN_I (RESETN_I),
        .PIN_I    (SCL_I),
        .LEVEL_O  (scl)
    );
    mss_pin_sync u_sda (
        .CLK_I    (CLK_I),
        .RESETN_I (RESETN_I),
        .PIN_I    (SDA_I),
        .LEVEL_O  (sda)
    );
    // R1 straps are pins too, so they pass the same filter as the bus lines.
    generate
        for (g = 0; g < 3; g = g + 1) begin : g_strap
            mss_pin_sync u_strap (
                .CLK_I    (CLK_I),
                .RESETN_I (RESETN_I),
                .PIN_I    (ADDR_STRAP_I[g]),
                .LEVEL_O  (strap[g])
            );
        end
    endgenerate

    wire scl_rise = scl & ~scl_d_reg;
    wire scl_fall = ~scl & scl_d_reg;
    wire start_c  = scl & scl_d_reg & sda_d_reg & ~sda;
    wire stop_c   = scl & scl_d_reg & ~sda_d_reg & sda;
    wire [7:0] rx_byte = {shift_reg[6:0], sda};

    assign rd_idx    = {RD_PORT_I, RD_OFFSET_I};
    assign tx_idx    = {port_reg[1:0], off_reg};
    assign RD_DATA_O = mem[rd_idx];
    // R2 slave only; the block never stretches the clock.
    assign SCL_O     = 1'b0;
    assign SCL_OE_O  = 1'b0;
    assign SDA_O     = 1'b0;
    assign SDA_OE_O  = sda_low_reg;

    // R1 strap capture. Straps are taken after reset release, never at reset.
    always @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            my_addr_reg <= `MSS_ADDR_INIT;
        end else if (state_reg == ST_IDLE) begin
            my_addr_reg <= {`MSS_ADDR_HI, strap};
        end
    end

    // R3 R4 register store; every word is writable whatever its usual access.
    always @(posedge CLK_I) begin
        if (WR_STROBE_O) begin
            mem[{WR_PORT_O, WR_OFFSET_O}] <= WR_DATA_O;
        end
    end

    always @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            scl_d_reg   <= 1'b1;
            sda_d_reg   <= 1'b1;
            state_reg   <= ST_IDLE;
            bit_reg     <= 4'h0;
            shift_reg   <= 8'h00;
            byte_reg    <= 3'h0;
            ack_reg     <= 1'b0;
            sda_low_reg <= 1'b0;
            cmd_ok_reg  <= 1'b0;
            tgt_reg     <= 1'b0;
            tx_hi_reg   <= 1'b0;
            mack_reg    <= 1'b0;
            off_reg     <= 8'h00;
            port_reg    <= 8'h00;
            dlo_reg     <= 8'h00;
            WR_STROBE_O <= 1'b0;
            WR_PORT_O   <= 2'h0;
            WR_OFFSET_O <= 8'h00;
            WR_DATA_O   <= `MSS_REG_INIT;
        end else begin
            scl_d_reg   <= scl;
            sda_d_reg   <= sda;
            WR_STROBE_O <= 1'b0;
            if (start_c) begin
                state_reg   <= ST_ADDR;
                bit_reg     <= 4'h0;
                sda_low_reg <= 1'b0;
                ack_reg     <= 1'b0;
            end else if (stop_c) begin
                state_reg   <= ST_IDLE;
                sda_low_reg <= 1'b0;
                ack_reg     <= 1'b0;
            end else if (scl_rise && state_reg != ST_IDLE && state_reg != ST_SKIP) begin
                if (bit_reg < 4'h8) begin
                    shift_reg <= rx_byte;
                    bit_reg   <= bit_reg + 4'h1;
                end else begin
                    // R9 master acknowledge sampled during read.
                    mack_reg <= ~sda;
                    bit_reg  <= 4'h9;
                end
            end else if (scl_fall) begin
                if (bit_reg == 4'h8 && !ack_reg && state_reg != ST_TX) begin
                    ack_reg <= 1'b1;
                    case (state_reg)
                        ST_ADDR: begin
                            // R10 address match and direction bit.
                            if (shift_reg[7:1] == my_addr_reg) begin
                                sda_low_reg <= 1'b1;
                                byte_reg    <= 3'h0;
                                if (shift_reg[0]) begin
                                    tx_hi_reg <= 1'b0;
                                    // A read uses up the pending target.
                                    tgt_reg   <= 1'b0;
                                end
                            end else begin
                                state_reg <= ST_SKIP;
                            end
                        end
                        ST_RX: begin
                            sda_low_reg <= 1'b1;
                            // R9 bytes after the second data byte are refused.
                            if (byte_reg != 3'h3) begin
                                byte_reg <= byte_reg + 3'h1;
                            end
                            if (byte_reg == 3'h0) begin
                                // R5 command code check.
                                cmd_ok_reg <= (shift_reg == `MSS_CMD_CFG);
                                // R13 a bad command drops any pending target.
                                if (shift_reg != `MSS_CMD_CFG) begin
                                    tgt_reg <= 1'b0;
                                end
                            end else if (byte_reg == 3'h1) begin
                                dlo_reg <= shift_reg;
                                // R6 offset latched for a target transaction.
                                if (cmd_ok_reg && !tgt_reg) begin
                                    off_reg <= shift_reg;
                                end
                            end else if (byte_reg == 3'h2) begin
                                // Both kinds look alike on the wire, so they must alternate.
                                tgt_reg <= cmd_ok_reg && !tgt_reg;
                                // R12 commit in the same cycle as the second data byte ack is driven.
                                // R13 commit only for good command and port.
                                if (cmd_ok_reg && tgt_reg && port_reg <= `MSS_PORT_MAX) begin
                                    WR_STROBE_O <= 1'b1;
                                    // R8 high byte completes the word.
                                    WR_DATA_O   <= {shift_reg, dlo_reg};
                                    WR_PORT_O   <= port_reg[1:0];
                                    WR_OFFSET_O <= off_reg;
                                end
                            end else begin
                                sda_low_reg <= 1'b0;
                            end
                        end
                        default: begin
                            sda_low_reg <= 1'b0;
                        end
                    endcase
                end else if (bit_reg == 4'h8 && state_reg == ST_TX) begin
                    sda_low_reg <= 1'b0;
                end else if (bit_reg == 4'h9) begin
                    bit_reg     <= 4'h0;
                    ack_reg     <= 1'b0;
                    sda_low_reg <= 1'b0;
                    if (state_reg == ST_ADDR) begin
                        state_reg <= shift_reg[0] ? ST_TX : ST_RX;
                    end
                    if ((state_reg == ST_ADDR && shift_reg[0]) ||
                        (state_reg == ST_TX && mack_reg)) begin
                        // R11 read data, low byte first.
                        shift_reg   <= tx_hi_reg ? mem[tx_idx][15:8] : mem[tx_idx][7:0];
                        tx_hi_reg   <= ~tx_hi_reg;
                        sda_low_reg <= tx_hi_reg ? ~mem[tx_idx][15] : ~mem[tx_idx][7];
                    end else if (state_reg == ST_TX) begin
                        state_reg <= ST_SKIP;
                    end
                end else if (state_reg == ST_TX && bit_reg != 4'h0) begin
                    sda_low_reg <= ~shift_reg[7];
                end
            end
        end
    end

    // R6 R7 port byte is the second data byte of a target transaction.
    always @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            port_reg <= `MSS_PORT_INIT;
        end else if (scl_fall && bit_reg == 4'h8 && !ack_reg && state_reg == ST_RX &&
                     byte_reg == 3'h2 && cmd_ok_reg && !tgt_reg) begin
            port_reg <= shift_reg;
        end
    end
endmodule // mss_slave

/* hw/mss_map.vh */
// Constants for the management serial configuration slave.
`ifndef MSS_MAP_VH
`define MSS_MAP_VH
`define MSS_ADDR_HI      4'hb
`define MSS_CMD_CFG      8'h08
`define MSS_PORT_MAX     8'h03
`define MSS_NUM_PORTS    4
`define MSS_REG_INIT     16'h0000
`define MSS_ADDR_INIT    7'h58
`define MSS_PORT_INIT    8'hff
`endif

/* hw/mss_pin_sync.v */
// Three-stage synchroniser with agreement filter for one pin.
`timescale 1ns/1ns
module mss_pin_sync (
    // Clock and reset
    input  wire CLK_I,
    input  wire RESETN_I,
    // Pin in, filtered level out
    input  wire PIN_I,
    output wire LEVEL_O
);
    reg [2:0] stage_reg;
    reg       level_reg;
    always @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            stage_reg <= 3'h7;
            level_reg <= 1'b1;
        end else begin
            stage_reg <= {stage_reg[1:0], PIN_I};
            // Only the second and third stages vote; the first may be metastable.
            if (stage_reg[1] == stage_reg[2]) begin
                level_reg <= stage_reg[2];
            end
        end
    end
    assign LEVEL_O = level_reg;
endmodule // mss_pin_sync

/* tb/mss_slave_properties.sv */
// Checker for the serial slave port relations.
`timescale 1ns/1ns
module mss_slave_properties (
    // Clock, reset and pins
    input wire        CLK_I,
    input wire        RESETN_I,
    input wire        SCL_I,
    input wire        SCL_OE_O,
    input wire        SDA_O,
    input wire        SDA_OE_O,
    // Register view
    input wire [1:0]  RD_PORT_I,
    input wire [7:0]  RD_OFFSET_I,
    input wire [15:0] RD_DATA_O,
    input wire        WR_STROBE_O,
    input wire [1:0]  WR_PORT_O,
    input wire [7:0]  WR_OFFSET_O,
    input wire [15:0] WR_DATA_O
);
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RESETN_I);
    a_scl_not_driven: assert property (!SCL_OE_O)
        else $error("clock line driven by slave");
    a_sda_open_drain: assert property (SDA_OE_O |-> !SDA_O)
        else $error("data line driven high");
    a_strobe_one_cycle: assert property (WR_STROBE_O |=> !WR_STROBE_O)
        else $error("write strobe longer than one cycle");
    a_data_held: assert property ($changed(WR_DATA_O) |-> ##[0:1] WR_STROBE_O)
        else $error("write data moved without strobe");
    a_target_held: assert property (($changed(WR_OFFSET_O) || $changed(WR_PORT_O))
        |-> ##[0:1] WR_STROBE_O)
        else $error("write target moved without strobe");
    a_sda_scl_low: assert property ($changed(SDA_OE_O) |-> !SCL_I)
        else $error("data line changed while clock high");
    a_strobe_scl_low: assert property (WR_STROBE_O |-> !SCL_I)
        else $error("strobe outside acknowledge low phase");
    a_read_back: assert property ((WR_STROBE_O && RD_PORT_I == WR_PORT_O
        && RD_OFFSET_I == WR_OFFSET_O) |-> ##2 (RD_DATA_O == WR_DATA_O))
        else $error("written word not readable");
endmodule // mss_slave_properties
bind mss_slave mss_slave_properties u_props (.CLK_I, .RESETN_I, .SCL_I, .SCL_OE_O, .SDA_O,
    .SDA_OE_O, .RD_PORT_I, .RD_OFFSET_I, .RD_DATA_O, .WR_STROBE_O, .WR_PORT_O, .WR_OFFSET_O,
    .WR_DATA_O);

/* tb/mss_master_model.sv */
// Bus master model that works the two-wire link through open-drain pulls.
`timescale 1ns/1ns
module mss_master_model (
    // Wire levels
    input  wire SCL_I,
    input  wire SDA_I,
    // Pulls, high drags the line low
    output reg  SCL_LOW_O,
    output reg  SDA_LOW_O
);
    // Quarter period; the clock stands high between frames.
    localparam Q = 16;
    initial begin
        SCL_LOW_O = 1'b0;
        SDA_LOW_O = 1'b0;
    end
    task start;
    begin
        SDA_LOW_O = 1'b0;
        #Q SCL_LOW_O = 1'b0;
        #Q SDA_LOW_O = 1'b1;
        #Q SCL_LOW_O = 1'b1;
        #Q;
    end
    endtask
    task stop;
    begin
        SDA_LOW_O = 1'b1;
        #Q SCL_LOW_O = 1'b0;
        #Q SDA_LOW_O = 1'b0;
        #Q;
    end
    endtask
    // eight bits high first, then the acknowledge slot
    task xfer(input [7:0] d, input mack, output [7:0] q, output sack);
        integer   i;
        reg [8:0] w;
        reg [8:0] r;
    begin
        w = {d, mack};
        for (i = 8; i >= 0; i = i - 1) begin
            SDA_LOW_O = !w[i];
            #Q SCL_LOW_O = 1'b0;
            #Q r = {r[7:0], SDA_I};
            #Q SCL_LOW_O = 1'b1;
            #Q;
        end
        q = r[8:1];
        sack = r[0];
    end
    endtask
endmodule // mss_master_model

/* tb/mss_slave_tb.sv */
// Self-checking bench for the serial configuration slave.
`timescale 1ns/1ns
module mss_slave_tb;
    reg         clk = 1'b0;
    reg         rst_n = 1'b0;
    reg  [2:0]  strap = 3'h0;
    reg  [1:0]  rd_port = 2'h0;
    reg  [7:0]  rd_off = 8'h00;
    wire        scl_o, scl_oe, sda_o, sda_oe, m_scl, m_sda, stb;
    wire [1:0]  wr_port;
    wire [7:0]  wr_off;
    wire [15:0] rd_data, wr_data;
    wire        scl = (scl_oe ? scl_o : 1'b1) & !m_scl;
    wire        sda = (sda_oe ? sda_o : 1'b1) & !m_sda;
    integer     fail_count = 0;
    integer     comparisons = 0;
    integer     strobes = 0;
    always #2 clk = ~clk;
    always @(negedge clk) if (stb === 1'b1) strobes = strobes + 1;
    mss_slave dut (.CLK_I(clk), .RESETN_I(rst_n), .ADDR_STRAP_I(strap), .SCL_I(scl),
        .SCL_O(scl_o), .SCL_OE_O(scl_oe), .SDA_I(sda), .SDA_O(sda_o), .SDA_OE_O(sda_oe),
        .RD_PORT_I(rd_port), .RD_OFFSET_I(rd_off), .RD_DATA_O(rd_data), .WR_STROBE_O(stb),
        .WR_PORT_O(wr_port), .WR_OFFSET_O(wr_off), .WR_DATA_O(wr_data));
    mss_master_model m (.SCL_I(scl), .SDA_I(sda), .SCL_LOW_O(m_scl), .SDA_LOW_O(m_sda));
    task check(input [15:0] seen, input [15:0] exp);
    begin
        comparisons = comparisons + 1;
        if (seen !== exp) begin
            fail_count = fail_count + 1;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    end
    endtask
    task give_verdict;
    begin
        if (fail_count == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    end
    endtask
    // fixed upper bits, straps below, direction last
    function [7:0] adr(input rd);
        adr = {4'hb, strap, rd};
    endfunction
    task txn(input [7:0] a, input [7:0] c, input [7:0] b1, input [7:0] b2, output [3:0] ak);
        reg [7:0] q;
    begin
        @(posedge clk);
        #1;
        m.start;
        m.xfer(a, 1'b1, q, ak[0]);
        m.xfer(c, 1'b1, q, ak[1]);
        m.xfer(b1, 1'b1, q, ak[2]);
        m.xfer(b2, 1'b1, q, ak[3]);
        m.stop;
    end
    endtask
    task s_write;
        reg [3:0] ak;
        integer   p;
    begin
        for (p = 0; p < 4; p = p + 1) begin
            strap = p[2:0] + 3'h3;
            rd_port = p[1:0];
            rd_off = 8'hb4 - p[7:0];
            txn(adr(1'b0), 8'h08, rd_off, {6'h00, rd_port}, ak);
            check(ak, 4'h0);
            txn(adr(1'b0), 8'h08, 8'h34 + p[7:0], 8'h12, ak);
            check(ak, 4'h0);
            check(strobes[15:0], p[15:0] + 16'h1);
            check(wr_port, rd_port);
            check(wr_off, rd_off);
            check(wr_data, {8'h12, 8'h34 + p[7:0]});
            check(rd_data, {8'h12, 8'h34 + p[7:0]});
        end
    end
    endtask
    task s_refuse;
        reg [3:0] ak;
    begin
        txn({4'hf, strap, 1'b0}, 8'h08, 8'h10, 8'h00, ak);
        check(ak[0], 1'b1);
        txn(adr(1'b0), 8'h08, 8'h10, 8'h04, ak);
        txn(adr(1'b0), 8'h08, 8'h55, 8'haa, ak);
        check(strobes[15:0], 16'h4);
        txn(adr(1'b0), 8'h08, 8'h10, 8'h02, ak);
        txn(adr(1'b0), 8'h09, 8'h55, 8'haa, ak);
        check(strobes[15:0], 16'h4);
    end
    endtask
    task s_read;
        reg [7:0] lo;
        reg [7:0] hi;
        reg [3:0] ak;
    begin
        txn(adr(1'b0), 8'h08, 8'hb1, 8'h03, ak);
        m.start;
        m.xfer(adr(1'b0), 1'b1, lo, ak[0]);
        m.xfer(8'h08, 1'b1, lo, ak[1]);
        m.start;
        m.xfer(adr(1'b1), 1'b1, lo, ak[2]);
        m.xfer(8'hff, 1'b0, lo, ak[3]);
        m.xfer(8'hff, 1'b1, hi, ak[3]);
        m.stop;
        check(ak[2:0], 3'h0);
        check({hi, lo}, 16'h1237);
        check(strobes[15:0], 16'h4);
    end
    endtask
    initial begin
        #200000;
        fail_count = fail_count + 1;
        give_verdict;
    end
    initial begin
        repeat (12) @(posedge clk);
        #1 rst_n = 1'b1;
        s_write;
        s_refuse;
        s_read;
        give_verdict;
    end
endmodule // mss_slave_tb
